// ---- gpio_port_map.vh ----
// Register map, reset values and field positions for the eight-bit I/O port.
// Included by the port register design file only; definitions only.
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// Byte addresses, compared on the low sixteen address bits
`define PORT_DIRECTION_ADDR     16'hffd1
`define PORT_OUTPUT_LATCH_ADDR  16'hffd3
`define PORT_ADDR_CMP_BITS      16

// Reset values and the direction read value
`define DIRECTION_RESET_MODE1   8'h00
`define DIRECTION_RESET_MODE3   8'h80
`define LATCH_RESET             8'h00
`define DIRECTION_READ_VALUE    8'hff

// Field positions
`define PIN_SEVEN_BIT           7

// Answer to an unmapped read
`define UNMAPPED_READ_VALUE     32'h0000_0000

`endif

// ---- port_pin_cell.v ----
// One port pin: output enable, driven level and read-back selection.
// Assumes the direction and latch bits come from registers in the parent.
`timescale 1ns/1ps
module port_pin_cell (
  // Clock and reset
  input  wire clk_in,
  input  wire nrst_in,
  // Register bits
  input  wire direction_bit_in,
  input  wire latch_bit_in,
  // Pin
  input  wire pin_level_in,
  output reg  pin_out,
  output reg  pin_oe_out,
  // Read-back
  output wire read_bit_out
);

  // Output pins read the latch, input pins read the pin level
  assign read_bit_out = direction_bit_in ? latch_bit_in
                                         : pin_level_in;

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_out    <= 1'b0;
      pin_oe_out <= 1'b0;
    end else begin
      pin_oe_out <= direction_bit_in;
      pin_out    <= latch_bit_in;
    end
  end

endmodule

// ---- eight_bit_io_port_regs.v ----
// Eight-bit general-purpose I/O port with direction and output latch
// registers on an Avalon-MM slave.
// Assumes pins are synchronous to clk_in and mode_three_in is static.
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module eight_bit_io_port_regs #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             nrst_in,
  // Operating state
  input  wire             mode_three_in,
  input  wire             hw_standby_in,
  input  wire             sw_standby_in,
  // Avalon-MM slave
  input  wire [31:0]      avs_address_in,
  input  wire             avs_read_in,
  input  wire             avs_write_in,
  input  wire [3:0]       avs_byteenable_in,
  input  wire [31:0]      avs_writedata_in,
  output reg  [31:0]      avs_readdata_out,
  output reg              avs_waitrequest_out,
  // Port pins
  input  wire [WIDTH-1:0] port_pin_in,
  output wire [WIDTH-1:0] port_pin_out,
  output wire [WIDTH-1:0] port_pin_oe_out
);

  reg  [WIDTH-1:0] port_direction_q;
  reg  [WIDTH-1:0] port_output_latch_q;
  reg              ack_q;
  wire [WIDTH-1:0] port_read_value;
  wire [15:0]      low_addr;
  wire             hit_direction;
  wire             hit_latch;
  wire [1:0]       lane;
  wire             lane_enabled;
  wire [WIDTH-1:0] lane_data;
  wire             access;
  wire             accept;
  wire [WIDTH-1:0] direction_reset;

  assign low_addr      = avs_address_in[`PORT_ADDR_CMP_BITS-1:0];
  assign hit_direction = (low_addr == `PORT_DIRECTION_ADDR);
  assign hit_latch     = (low_addr == `PORT_OUTPUT_LATCH_ADDR);
  // Byte addresses select a lane of the 32-bit data bus
  assign lane          = avs_address_in[1:0];
  assign lane_enabled  = avs_byteenable_in[lane];
  assign lane_data     = avs_writedata_in[lane*8 +: WIDTH];
  assign access        = avs_read_in | avs_write_in;
  // One wait cycle, then the request is taken
  assign accept        = access & ack_q;

  assign direction_reset = mode_three_in ? `DIRECTION_RESET_MODE3
                                         : `DIRECTION_RESET_MODE1;

  // Reset and hardware standby both initialise; software standby keeps all
  always @(posedge clk_in) begin
    if (!nrst_in || hw_standby_in) begin
      port_direction_q    <= direction_reset;
      port_output_latch_q <= `LATCH_RESET;
    end else if (accept && avs_write_in && lane_enabled &&
                 !sw_standby_in) begin
      if (hit_direction) begin
        port_direction_q <= lane_data;
        if (mode_three_in)
          port_direction_q[`PIN_SEVEN_BIT] <= 1'b1;
      end
      if (hit_latch)
        port_output_latch_q <= lane_data;
    end
  end

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      ack_q               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= `UNMAPPED_READ_VALUE;
    end else begin
      ack_q               <= access & ~ack_q;
      avs_waitrequest_out <= ~(access & ~ack_q);
      if (avs_read_in && !ack_q) begin
        avs_readdata_out <= `UNMAPPED_READ_VALUE;
        if (hit_direction)
          avs_readdata_out[lane*8 +: WIDTH] <=
            `DIRECTION_READ_VALUE;
        else if (hit_latch)
          avs_readdata_out[lane*8 +: WIDTH] <= port_read_value;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      port_pin_cell u_cell (
        .clk_in           (clk_in),
        .nrst_in          (nrst_in),
        .direction_bit_in (port_direction_q[i]),
        .latch_bit_in     (port_output_latch_q[i]),
        .pin_level_in     (port_pin_in[i]),
        .pin_out          (port_pin_out[i]),
        .pin_oe_out       (port_pin_oe_out[i]),
        .read_bit_out     (port_read_value[i])
      );
    end
  endgenerate

endmodule

// ---- port_pins_model.sv ----
// Outside circuitry on the eight port pins.
// Drives input pins from drive_in; output pins carry the port's level.
`timescale 1ns/1ps
module port_pins_model (input wire [7:0] drive_in, out_in, oe_in,
  output wire [7:0] level_out);
  assign level_out = oe_in & out_in | ~oe_in & drive_in;
endmodule

// ---- eight_bit_io_port_regs_props.sv ----
// Checker for the port block: bus answers, read-back, pin updates.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module eight_bit_io_port_regs_props #(parameter WIDTH = 8) (
  input wire clk_in, nrst_in, mode_three_in, hw_standby_in, sw_standby_in,
  input wire avs_read_in, avs_write_in, avs_waitrequest_out,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_address_in, avs_writedata_in, avs_readdata_out,
  input wire [WIDTH-1:0] port_pin_in, port_pin_out, port_pin_oe_out);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire ok = !avs_waitrequest_out;
  wire rd = avs_read_in && ok;
  wire wr = avs_write_in && ok && !sw_standby_in && !hw_standby_in;
  wire [15:0] a = avs_address_in[15:0];
  wire [7:0] q = avs_readdata_out[31:24];
  wait_one_a: assert property ($rose(avs_read_in | avs_write_in)
    |=> ok) else $error("late answer");
  dir_read_a: assert property (rd && a == 16'hffd1
    |-> avs_readdata_out == 32'h0000_ff00) else $error("dir read");
  out_read_a: assert property (rd && a == 16'hffd3
    |-> ((q ^ port_pin_out) & port_pin_oe_out) == 0) else $error("out read");
  in_read_a: assert property (rd && a == 16'hffd3
    |-> ((q ^ $past(port_pin_in)) & ~port_pin_oe_out) == 0) else $error("in");
  unmapped_a: assert property (rd && a != 16'hffd1 && a != 16'hffd3
    |-> avs_readdata_out == 0) else $error("unmapped");
  latch_drive_a: assert property (wr && a == 16'hffd3
    && avs_byteenable_in[3]
    |-> ##2 port_pin_out == $past(avs_writedata_in[31:24], 2))
    else $error("latch");
  sw_hold_a: assert property (sw_standby_in && $past(sw_standby_in)
    && $past(sw_standby_in, 2) |-> $stable(port_pin_out)) else $error("hold");
  mode_three_a: assert property (mode_three_in && $past(nrst_in)
    && !$past(hw_standby_in) |-> port_pin_oe_out[7]) else $error("bit 7");
endmodule
bind eight_bit_io_port_regs eight_bit_io_port_regs_props #(.WIDTH(WIDTH)) p (.*);

// ---- tb_eight_bit_io_port_regs.sv ----
// Bench for the port block: Avalon-MM tasks, pin model, random traffic.
// Assumes one wait cycle per request and registered pin outputs.
`timescale 1ns/1ps
module tb_eight_bit_io_port_regs;
  logic clk_in = 0, nrst_in = 0, mode_three_in = 0, hw_standby_in = 0;
  logic sw_standby_in = 0, avs_read_in = 0, avs_write_in = 0;
  logic [3:0] avs_byteenable_in = 0;
  logic [31:0] avs_address_in = 0, avs_writedata_in = 0;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out;
  wire [7:0] port_pin_in, port_pin_out, port_pin_oe_out;
  logic [7:0] ext = 0, d, l, x, rd;
  int n_fail = 0, checks = 0, cyc = 0;
  eight_bit_io_port_regs eight_bit_io_port_regs_inst (.*);
  port_pins_model port_pins_model_inst (.drive_in(ext), .out_in(port_pin_out),
    .oe_in(port_pin_oe_out), .level_out(port_pin_in));
  initial forever #10 clk_in = ~clk_in;
  always @(posedge clk_in) if (++cyc == 2000) begin n_fail++; end_of_test(); end
  function logic [7:0] exp_port(input logic [7:0] d, l, p);
    return d & l | ~d & p;
  endfunction
  task cmp(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin n_fail++; $display("wrong value %0t %h %h", $time, g, e); end
  endtask
  task bus(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    avs_address_in <= {16'($urandom), a};
    avs_byteenable_in <= 4'b0001 << a[1:0];
    avs_writedata_in <= {4{v}};
    avs_read_in <= !w;
    avs_write_in <= w;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = 8'(avs_readdata_out >> {a[1:0], 3'b000});
    avs_read_in <= 0;
    avs_write_in <= 0;
  endtask
  task end_of_test();
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h4128));
    repeat (2) @(posedge clk_in);
    nrst_in <= 1;
    x = $urandom;
    ext <= x;
    cmp(port_pin_oe_out, 8'h00);
    bus(0, 16'hffd1, 0); cmp(rd, 8'hff);
    bus(0, 16'hffd3, 0); cmp(rd, x);
    repeat (20) begin
      {d, l, x} = $urandom;
      ext <= x;
      bus(1, 16'hffd1, d); bus(1, 16'hffd3, l); bus(0, 16'hffd3, 0);
      cmp(rd, exp_port(d, l, x));
      cmp(port_pin_oe_out, d);
      cmp(port_pin_out, l);
    end
    sw_standby_in <= 1;
    bus(1, 16'hffd3, ~l); bus(1, 16'hffd1, ~d);
    cmp(port_pin_out, l);
    cmp(port_pin_oe_out, d);
    bus(0, 16'hffd5, 0); cmp(rd, 0);
    sw_standby_in <= 0; hw_standby_in <= 1;
    repeat (2) @(posedge clk_in);
    hw_standby_in <= 0;
    bus(0, 16'hffd3, 0); cmp(rd, x);
    cmp(port_pin_out, 0);
    cmp(port_pin_oe_out, 0);
    nrst_in <= 0; mode_three_in <= 1;
    @(posedge clk_in);
    nrst_in <= 1;
    bus(1, 16'hffd1, 0); bus(0, 16'hffd1, 0);
    cmp(port_pin_oe_out, 8'h80);
    end_of_test();
  end
endmodule
